// File: pkg/sysctl_pkg.sv
// package: register map, field layout, reset values and state types of the system control unit
package sysctl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NPERIPH = 8;
  localparam int NIRQ = 7;
  localparam int NRST = 5;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CLKSEL = 12'h000;
  localparam logic [11:0] OFS_OSCCTL = 12'h004;
  localparam logic [11:0] OFS_RUNEN = 12'h008;
  localparam logic [11:0] OFS_SLPEN = 12'h00C;
  localparam logic [11:0] OFS_DSLPEN = 12'h010;
  localparam logic [11:0] OFS_PRST = 12'h014;
  localparam logic [11:0] OFS_MODE = 12'h018;
  localparam logic [11:0] OFS_IRQEN = 12'h01C;
  localparam logic [11:0] OFS_IRQST = 12'h020;
  localparam logic [11:0] OFS_RSTCAUSE = 12'h024;
  localparam logic [11:0] OFS_RSTCFG = 12'h028;
  localparam logic [11:0] OFS_SWRST = 12'h02C;
  localparam logic [11:0] OFS_ADCRATE = 12'h030;
  localparam logic [11:0] OFS_PWMDIV = 12'h034;
  localparam logic [11:0] OFS_ID_MEM = 12'h038;
  localparam logic [11:0] OFS_ID_PER = 12'h03C;
  localparam logic [11:0] OFS_ID_PIN = 12'h040;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_REF_LSB = 4;
  localparam int OSC_MAIN_DIS = 0;
  localparam int OSC_INT_DIS = 1;
  localparam int PRST_PULSE_LSB = 8;
  localparam int MODE_DEEP = 0;
  localparam int MODE_GO = 1;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_MAIN = 3'h1;
  localparam logic [2:0] SRC_INT = 3'h2;
  localparam logic [2:0] SRC_INT4 = 3'h3;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam logic [1:0] adc_rate_one_msps = 2'h3;
  localparam logic [1:0] adc_rate_half_msps = 2'h2;
  localparam logic [1:0] adc_rate_quarter_msps = 2'h1;
  localparam logic [1:0] adc_rate_eighth_msps = 2'h0;
  localparam logic [2:0] RST_CLKSRC = SRC_INT;
  localparam logic [1:0] RST_CLKREF = 2'h1;
  localparam logic [1:0] RST_ADCRATE = adc_rate_eighth_msps;
  localparam logic [7:0] RST_PWMDIV = 8'h00;
  localparam logic [NRST-1:0] RST_RSTCFG = 5'h1F;
  localparam logic [7:0] RST_RUNEN = 8'h00;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DSLEEP = 3'b100
  } pmode_e;

  // cause bits: 0 input brown-out, 1 regulator brown-out, 2 pin, 3 software, 4 watchdog
  typedef struct packed {
    logic [NRST-1:0] cause;
    logic [NRST-1:0] cfg;
  } rst_s;

  // irq bits: 0 lock, 1 current limit, 2 int osc fail, 3 main osc fail,
  // 4 supply low, 5 regulator low, 6 loop fail
  typedef struct packed {
    logic [NIRQ-1:0] en;
    logic [NIRQ-1:0] st;
  } irq_s;

endpackage : sysctl_pkg

// File: rtl/sysctl.sv
// system clock, reset and power-mode control unit behind an apb slave
// ------------------------------------------------------------------
// rules
// ------------------------------------------------------------------
// Operation
// - clock from one of five sources
// - loop reference from any four oscillators
// - run, sleep, deep-sleep; sleep stops cpu clock
// - deep-sleep stops cpu clock, drops loop
// - sleep on request, wake on interrupt
// - reset on five listed events
// - record reset cause; some causes configurable
// - per-peripheral clock enable and reset control
// - separate sleep and deep-sleep enable sets
// - interrupt on seven clock/supply events
// - per-source enable, sticky until cleared
// - read-only memory, peripheral, pin identity
// - four selectable converter sample rates
// - rate read back is rate in use
// - peripherals at cpu rate, pwm divided
// - active oscillator cannot be disabled
`timescale 1ns/100ps
`default_nettype none
module sysctl
  import sysctl_pkg::*;
#(
  parameter logic [31:0] ID_MEM = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] ID_PER = 32'h0000_00FF, // arbitrary value
  parameter logic [31:0] ID_PIN = 32'h0000_0F0F, // arbitrary value
  parameter logic [1:0] ADC_MAX = adc_rate_one_msps
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous event pins
  input wire logic [NIRQ-1:0] irq_event_in,
  input wire logic [NRST-1:0] rst_event_in,
  input wire logic wake_irq_in,
  input wire logic cpu_sleep_req,
  // clock, peripheral reset and rate control
  output logic [2:0] clk_src_sel,
  output logic [1:0] pll_ref_sel,
  output logic pll_enable,
  output logic main_osc_off,
  output logic int_osc_off,
  output logic cpu_clk_en,
  output logic [NPERIPH-1:0] periph_clk_en,
  output logic [NPERIPH-1:0] periph_rst,
  output logic [7:0] pwm_div,
  output logic [1:0] adc_rate,
  // system reset and interrupt
  output logic sys_reset_req,
  output logic sysctl_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NIRQ-1:0] irq_m;
    logic [NIRQ-1:0] irq_q;
    logic [NIRQ-1:0] irq_p;
    logic [NRST-1:0] rst_m;
    logic [NRST-1:0] rst_q;
    logic [NRST-1:0] rst_p;
    logic wk_m;
    logic wk_q;
    logic sr_m;
    logic sr_q;
    logic [2:0] src;
    logic [1:0] ref_sel;
    logic main_dis;
    logic int_dis;
    logic [NPERIPH-1:0] run_en;
    logic [NPERIPH-1:0] slp_en;
    logic [NPERIPH-1:0] dslp_en;
    logic [NPERIPH-1:0] prst_hold;
    logic [NPERIPH-1:0] prst_pulse;
    logic deep_sel;
    pmode_e mode;
    irq_s irq;
    rst_s rst;
    logic [1:0] adc;
    logic [7:0] pwm;
    logic sw_rst;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq_out;
    logic cpu_en;
    logic [NPERIPH-1:0] pclk_en;
    logic [NPERIPH-1:0] prst_out;
    logic [2:0] clk_sel;
    logic pll_on;
  } st_s;

  st_s s;
  st_s next_s;

  logic wr;
  logic rd;
  logic [NRST-1:0] rst_hit;
  logic [NIRQ-1:0] irq_hit;
  logic [1:0] adc_eff;

  assign wr = psel && penable && pwrite && !s.ready;
  assign rd = psel && penable && !pwrite && !s.ready;
  assign irq_hit = s.irq_q & ~s.irq_p;
  assign rst_hit = s.rst_q & ~s.rst_p & s.rst.cfg;
  // the hardware ceiling wins over the request
  assign adc_eff = (pwdata[1:0] > ADC_MAX) ? ADC_MAX : pwdata[1:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // two-stage synchronisers; stage two feeds logic, and a third irq/reset stage feeds the edge detect
    next_s.irq_m = irq_event_in;
    next_s.irq_q = s.irq_m;
    next_s.irq_p = s.irq_q;
    next_s.rst_m = rst_event_in;
    next_s.rst_q = s.rst_m;
    next_s.rst_p = s.rst_q;
    next_s.wk_m = wake_irq_in;
    next_s.wk_q = s.wk_m;
    next_s.sr_m = cpu_sleep_req;
    next_s.sr_q = s.sr_m;
    next_s.prst_pulse = '0;
    next_s.sw_rst = 1'b0;
    next_s.ready = psel && penable && !s.ready;
    next_s.err = 1'b0;
    next_s.rdata = 32'h0000_0000;

    if (wr) begin
      if (paddr == OFS_CLKSEL) begin
        if (pwdata[CLK_SRC_LSB +: 3] <= SRC_PLL) begin
          next_s.src = pwdata[CLK_SRC_LSB +: 3];
        end
        next_s.ref_sel = pwdata[CLK_REF_LSB +: 2];
      end else if (paddr == OFS_OSCCTL) begin
        next_s.main_dis = pwdata[OSC_MAIN_DIS];
        next_s.int_dis = pwdata[OSC_INT_DIS];
      end else if (paddr == OFS_RUNEN) begin
        next_s.run_en = pwdata[NPERIPH-1:0];
      end else if (paddr == OFS_SLPEN) begin
        next_s.slp_en = pwdata[NPERIPH-1:0];
      end else if (paddr == OFS_DSLPEN) begin
        next_s.dslp_en = pwdata[NPERIPH-1:0];
      end else if (paddr == OFS_PRST) begin
        next_s.prst_hold = pwdata[NPERIPH-1:0];
        next_s.prst_pulse = pwdata[PRST_PULSE_LSB +: NPERIPH];
      end else if (paddr == OFS_MODE) begin
        next_s.deep_sel = pwdata[MODE_DEEP];
      end else if (paddr == OFS_IRQEN) begin
        next_s.irq.en = pwdata[NIRQ-1:0];
      end else if (paddr == OFS_IRQST) begin
        next_s.irq.st = s.irq.st & ~pwdata[NIRQ-1:0];
      end else if (paddr == OFS_RSTCAUSE) begin
        next_s.rst.cause = s.rst.cause & ~pwdata[NRST-1:0];
      end else if (paddr == OFS_RSTCFG) begin
        next_s.rst.cfg = pwdata[NRST-1:0] | 5'h18;
      end else if (paddr == OFS_SWRST) begin
        next_s.sw_rst = pwdata[0];
      end else if (paddr == OFS_ADCRATE) begin
        next_s.adc = adc_eff;
      end else if (paddr == OFS_PWMDIV) begin
        next_s.pwm = pwdata[7:0];
      end else if (paddr == OFS_ID_MEM || paddr == OFS_ID_PER || paddr == OFS_ID_PIN) begin
        next_s.err = 1'b1;
      end else begin
        next_s.err = 1'b1;
      end
    end else if (rd) begin
      if (paddr == OFS_CLKSEL) begin
        next_s.rdata = {26'h0, s.ref_sel, 1'b0, s.src};
      end else if (paddr == OFS_OSCCTL) begin
        next_s.rdata = {30'h0, s.int_dis, s.main_dis};
      end else if (paddr == OFS_RUNEN) begin
        next_s.rdata = {24'h0, s.run_en};
      end else if (paddr == OFS_SLPEN) begin
        next_s.rdata = {24'h0, s.slp_en};
      end else if (paddr == OFS_DSLPEN) begin
        next_s.rdata = {24'h0, s.dslp_en};
      end else if (paddr == OFS_PRST) begin
        next_s.rdata = {24'h0, s.prst_hold};
      end else if (paddr == OFS_MODE) begin
        next_s.rdata = {28'h0, s.mode, s.deep_sel};
      end else if (paddr == OFS_IRQEN) begin
        next_s.rdata = {25'h0, s.irq.en};
      end else if (paddr == OFS_IRQST) begin
        next_s.rdata = {25'h0, s.irq.st};
      end else if (paddr == OFS_RSTCAUSE) begin
        next_s.rdata = {27'h0, s.rst.cause};
      end else if (paddr == OFS_RSTCFG) begin
        next_s.rdata = {27'h0, s.rst.cfg};
      end else if (paddr == OFS_SWRST) begin
        next_s.rdata = 32'h0000_0000;
      end else if (paddr == OFS_ADCRATE) begin
        next_s.rdata = {30'h0, s.adc};
      end else if (paddr == OFS_PWMDIV) begin
        next_s.rdata = {24'h0, s.pwm};
      end else if (paddr == OFS_ID_MEM) begin
        next_s.rdata = ID_MEM;
      end else if (paddr == OFS_ID_PER) begin
        next_s.rdata = ID_PER;
      end else if (paddr == OFS_ID_PIN) begin
        next_s.rdata = ID_PIN;
      end else begin
        next_s.err = 1'b1;
      end
    end

    // a source in use is never off; with the loop, main stays up for the deep-sleep fallback;
    // selecting a disabled source turns it back on rather than refusing the switch
    if (next_s.src == SRC_MAIN || next_s.src == SRC_PLL) begin
      next_s.main_dis = 1'b0;
    end
    if (next_s.src == SRC_INT || next_s.src == SRC_INT4
        || (next_s.src == SRC_PLL && next_s.ref_sel[1])) begin
      next_s.int_dis = 1'b0;
    end

    // hardware set wins over a same-cycle software clear
    next_s.irq.st = next_s.irq.st | irq_hit;
    // cause bits are cleared only by presetn or by a software write of one
    next_s.rst.cause = next_s.rst.cause | rst_hit | {1'b0, s.sw_rst, 3'h0};

    case (s.mode)
      MODE_RUN: begin
        if (s.sr_q) begin
          next_s.mode = s.deep_sel ? MODE_DSLEEP : MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (s.wk_q) begin
          next_s.mode = MODE_RUN;
        end
      end
      MODE_DSLEEP: begin
        if (s.wk_q) begin
          next_s.mode = MODE_RUN;
        end
      end
      default: begin
        next_s.mode = MODE_RUN;
      end
    endcase

    next_s.cpu_en = (next_s.mode == MODE_RUN);
    case (next_s.mode)
      MODE_SLEEP: next_s.pclk_en = s.slp_en & ~s.prst_hold;
      MODE_DSLEEP: next_s.pclk_en = s.dslp_en & ~s.prst_hold;
      default: next_s.pclk_en = s.run_en & ~s.prst_hold;
    endcase
    next_s.prst_out = next_s.prst_hold | next_s.prst_pulse;
    next_s.irq_out = |(next_s.irq.st & next_s.irq.en);
    // deep-sleep falls back to the crystal and drops the loop; registered, so no decode glitch
    next_s.clk_sel = (next_s.mode == MODE_DSLEEP && next_s.src == SRC_PLL)
                     ? SRC_MAIN : next_s.src;
    next_s.pll_on = (next_s.src == SRC_PLL) && (next_s.mode != MODE_DSLEEP);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.src <= RST_CLKSRC;
      s.clk_sel <= RST_CLKSRC;
      s.ref_sel <= RST_CLKREF;
      s.mode <= MODE_RUN;
      s.adc <= RST_ADCRATE;
      s.pwm <= RST_PWMDIV;
      s.run_en <= RST_RUNEN;
      s.rst.cfg <= RST_RSTCFG;
      s.cpu_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.err;
  assign clk_src_sel = s.clk_sel;
  assign pll_ref_sel = s.ref_sel;
  assign pll_enable = s.pll_on;
  assign main_osc_off = s.main_dis;
  assign int_osc_off = s.int_dis;
  assign cpu_clk_en = s.cpu_en;
  assign periph_clk_en = s.pclk_en;
  assign periph_rst = s.prst_out;
  assign pwm_div = s.pwm;
  assign adc_rate = s.adc;
  assign sys_reset_req = s.sw_rst;
  assign sysctl_irq = s.irq_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_hit[0]) |=> s.irq.st[0]) else $error("irq event not latched");
  a_irq_out: assert property (@(posedge pclk) disable iff (!presetn)
    sysctl_irq == $past(|(s.irq.st & s.irq.en) | |(irq_hit & s.irq.en)) || $past(wr))
    else $error("irq output mismatch");
  a_sleep_cpu: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode != MODE_RUN) |-> !cpu_clk_en) else $error("cpu clocked while asleep");
  a_wake_run: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode != MODE_RUN && s.wk_q) |=> s.mode == MODE_RUN) else $error("no wake");
  a_deep_pll: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == MODE_DSLEEP) |-> !pll_enable) else $error("loop used in deep-sleep");
  a_osc_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (s.src == SRC_MAIN) |-> !main_osc_off) else $error("active oscillator off");
  a_adc_limit: assert property (@(posedge pclk) disable iff (!presetn)
    adc_rate <= ADC_MAX) else $error("rate above ceiling");
  a_cause_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (s.rst.cause[4] && !(wr && paddr == OFS_RSTCAUSE)) |=> s.rst.cause[4])
    else $error("cause lost");
  a_sw_cause: assert property (@(posedge pclk) disable iff (!presetn)
    sys_reset_req |=> s.rst.cause[3]) else $error("software reset not recorded");
  a_int_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (s.src == SRC_INT || s.src == SRC_INT4) |-> !int_osc_off)
    else $error("internal oscillator off while in use");
  a_deep_clk: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == MODE_DSLEEP && s.src == SRC_PLL) |-> clk_src_sel == SRC_MAIN)
    else $error("loop still clocks deep-sleep");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("slave error without ready");
  a_cpu_run: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mode == MODE_RUN) |-> cpu_clk_en) else $error("cpu stopped while running");

endmodule : sysctl
`default_nettype wire

// File: verification/test_sysctl.sv
// self-checking testbench of the system control unit
`timescale 1ns/100ps
`default_nettype none
module test_sysctl;
  import sysctl_pkg::*;
  // ----------------------------------------------------------------
  // design and signals
  // ----------------------------------------------------------------
  localparam logic [31:0] TB_MEM = 32'h0000_A001; // arbitrary value
  localparam logic [31:0] TB_PER = 32'h0000_00B2; // arbitrary value
  localparam logic [31:0] TB_PIN = 32'h0000_0C03; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NIRQ-1:0] irq_event_in;
  logic [NRST-1:0] rst_event_in;
  logic wake_irq_in, cpu_sleep_req, pll_enable, main_osc_off, int_osc_off, cpu_clk_en;
  logic [2:0] clk_src_sel;
  logic [1:0] pll_ref_sel, adc_rate, exp_rate;
  logic [NPERIPH-1:0] periph_clk_en, periph_rst;
  logic [7:0] pwm_div;
  logic sys_reset_req, sysctl_irq;
  logic [1:0] rates [4] = '{adc_rate_one_msps, adc_rate_half_msps,
                            adc_rate_quarter_msps, adc_rate_eighth_msps};
  int err_total = 0;
  int check_count = 0;
  int reset_pulses = 0;
  int prst_pulses = 0;

  // rate capped below the fastest code so the clamp is exercised
  sysctl #(.ID_MEM(TB_MEM), .ID_PER(TB_PER), .ID_PIN(TB_PIN),
    .ADC_MAX(adc_rate_half_msps)) u_sysctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_event_in(irq_event_in), .rst_event_in(rst_event_in), .wake_irq_in(wake_irq_in),
    .cpu_sleep_req(cpu_sleep_req), .clk_src_sel(clk_src_sel), .pll_ref_sel(pll_ref_sel),
    .pll_enable(pll_enable), .main_osc_off(main_osc_off), .int_osc_off(int_osc_off),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .periph_rst(periph_rst),
    .pwm_div(pwm_div), .adc_rate(adc_rate), .sys_reset_req(sys_reset_req),
    .sysctl_irq(sysctl_irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // one-cycle pulses are counted as they pass
  always @(posedge pclk) begin
    if (sys_reset_req === 1'b1) reset_pulses <= reset_pulses + 1;
    if (periph_rst === 8'h02) prst_pulses <= prst_pulses + 1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_err(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t slave error %b expected %b", $time, got, exp);
    end
  endtask : chk_err

  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask : tick

  // request stands until pready is seen high at a rising edge; data and error taken there
  task automatic apb(input logic is_write, input logic [11:0] a, input logic [31:0] wd,
                     input logic exp_err, output logic [31:0] rdat);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_write;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t no bus answer", $time);
      complete_run();
    end
    rdat = prdata;
    chk_err(pslverr, exp_err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
    logic [31:0] r;
    apb(1'b1, a, d, e, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e = 1'b0);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, e, r);
    if (!e) chk(r, exp);
  endtask : rd

  task automatic wait_cpu(input logic exp);
    for (int i = 0; i < 20; i++) begin
      @(negedge pclk);
      if (cpu_clk_en === exp) return;
    end
    err_total++;
    $display("[ERR] %0t mode change missing", $time);
    complete_run();
  endtask : wait_cpu

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, wake_irq_in, cpu_sleep_req} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_event_in = '0;
    rst_event_in = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    chk(32'(clk_src_sel), 32'(RST_CLKSRC));
    // irq in bit 0, peripherals above it, then cpu, then loop
    chk(32'({pll_enable, cpu_clk_en, periph_clk_en, sysctl_irq}), 32'h0000_0200);
    chk(32'(adc_rate), 32'(RST_ADCRATE));
    rd(OFS_CLKSEL, 32'({RST_CLKREF, 1'b0, RST_CLKSRC}));
    done("reset");
    for (int s = 0; s < 5; s++) begin
      wr(OFS_CLKSEL, 32'(s + 16 * (s % 4)));
      tick(2);
      chk(32'({pll_enable, pll_ref_sel, clk_src_sel}), 32'({s == 4, 2'(s % 4), 3'(s)}));
    end
    wr(OFS_CLKSEL, 32'h0000_0005);
    tick(2);
    chk(32'(clk_src_sel), 32'(SRC_PLL));
    done("clock select");
    wr(OFS_CLKSEL, 32'(SRC_MAIN));
    wr(OFS_OSCCTL, 32'h0000_0003);
    tick(2);
    chk(32'({main_osc_off, int_osc_off}), 32'h0000_0001);
    wr(OFS_CLKSEL, 32'(SRC_INT));
    wr(OFS_OSCCTL, 32'h0000_0003);
    tick(2);
    chk(32'({main_osc_off, int_osc_off}), 32'h0000_0002);
    wr(OFS_OSCCTL, 32'h0000_0000);
    done("oscillator guard");
    wr(OFS_RUNEN, 32'h0000_00FF);
    wr(OFS_PRST, 32'h0000_0005);
    tick(2);
    chk(32'({periph_rst, periph_clk_en}), 32'h0000_05FA);
    wr(OFS_PRST, 32'h0000_0200);
    tick(3);
    chk(32'({periph_rst, 8'(prst_pulses)}), 32'h0000_0001);
    wr(OFS_PWMDIV, 32'h0000_005A);
    rd(OFS_PWMDIV, 32'h0000_005A);
    chk(32'(pwm_div), 32'h0000_005A);
    done("peripherals");
    wr(OFS_RUNEN, 32'h0000_000F);
    wr(OFS_SLPEN, 32'h0000_0030);
    // timer-like peripherals are left out of the deep-sleep set
    wr(OFS_DSLPEN, 32'h0000_00C0);
    // loop fed from the main crystal, a standard reference
    wr(OFS_CLKSEL, 32'h0000_0014);
    for (int d = 0; d < 2; d++) begin
      wr(OFS_MODE, 32'(d));
      @(posedge pclk);
      cpu_sleep_req <= 1'b1;
      wait_cpu(1'b0);
      tick(2);
      chk(32'(periph_clk_en), d ? 32'h0000_00C0 : 32'h0000_0030);
      chk(32'({pll_enable, clk_src_sel}), d ? 32'(SRC_MAIN) : 32'(SRC_PLL) + 8);
      rd(OFS_MODE, d ? 32'({MODE_DSLEEP, 1'b1}) : 32'({MODE_SLEEP, 1'b0}));
      cpu_sleep_req <= 1'b0;
      tick(6);
      chk(32'(cpu_clk_en), 32'h0000_0000);
      @(posedge pclk);
      wake_irq_in <= 1'b1;
      wait_cpu(1'b1);
      @(posedge pclk);
      wake_irq_in <= 1'b0;
      tick(2);
      chk(32'({pll_enable, periph_clk_en}), 32'h0000_010F);
    end
    rd(OFS_MODE, 32'({MODE_RUN, 1'b1}));
    done("sleep modes");
    wr(OFS_IRQEN, 32'h0000_007F);
    for (int i = 0; i < NIRQ; i++) begin
      @(posedge pclk);
      irq_event_in[i] <= 1'b1;
      tick(5);
      chk(32'(sysctl_irq), 32'h0000_0001);
      @(posedge pclk);
      irq_event_in[i] <= 1'b0;
      rd(OFS_IRQST, 32'h1 << i);
      wr(OFS_IRQST, 32'h1 << i);
      tick(2);
      chk(32'(sysctl_irq), 32'h0000_0000);
      rd(OFS_IRQST, 32'h0000_0000);
    end
    wr(OFS_IRQEN, 32'h0000_007E);
    @(posedge pclk);
    irq_event_in[0] <= 1'b1;
    tick(5);
    chk(32'(sysctl_irq), 32'h0000_0000);
    rd(OFS_IRQST, 32'h0000_0001);
    wr(OFS_IRQEN, 32'h0000_007F);
    tick(2);
    chk(32'(sysctl_irq), 32'h0000_0001);
    @(posedge pclk);
    irq_event_in <= '0;
    wr(OFS_IRQST, 32'h0000_007F);
    done("interrupts");
    for (int i = 0; i < NRST; i++) begin
      @(posedge pclk);
      rst_event_in[i] <= 1'b1;
      tick(5);
      rd(OFS_RSTCAUSE, 32'h1 << i);
      @(posedge pclk);
      rst_event_in[i] <= 1'b0;
      tick(5);
      rd(OFS_RSTCAUSE, 32'h1 << i);
      wr(OFS_RSTCAUSE, 32'h1 << i);
      rd(OFS_RSTCAUSE, 32'h0000_0000);
    end
    wr(OFS_RSTCFG, 32'h0000_001E);
    @(posedge pclk);
    rst_event_in[0] <= 1'b1;
    tick(5);
    rd(OFS_RSTCAUSE, 32'h0000_0000);
    rst_event_in <= '0;
    wr(OFS_SWRST, 32'h0000_0001);
    tick(3);
    chk(32'(reset_pulses), 32'h0000_0001);
    rd(OFS_RSTCAUSE, 32'h0000_0008);
    done("resets");
    rd(OFS_ID_MEM, TB_MEM);
    rd(OFS_ID_PER, TB_PER);
    wr(OFS_ID_PIN, 32'h0000_0000, 1'b1);
    rd(OFS_ID_PIN, TB_PIN);
    rd(12'h0FC, 32'h0000_0000, 1'b1);
    foreach (rates[k]) begin
      exp_rate = (rates[k] > adc_rate_half_msps) ? adc_rate_half_msps : rates[k];
      wr(OFS_ADCRATE, 32'(rates[k]));
      rd(OFS_ADCRATE, 32'(exp_rate));
      chk(32'(adc_rate), 32'(exp_rate));
    end
    done("identity and rate");
    complete_run();
  end
endmodule : test_sysctl
`default_nettype wire
